// File: design/gcs_cfg.svh
`ifndef GCS_CFG_SVH
`define GCS_CFG_SVH

// reference clock rate in hertz (50 ns period)
`define GCS_REF_CLK_HZ 20000000

// dynamic select codes, one per runtime-selectable input
`define GCS_SEL_DED0 2'h0
`define GCS_SEL_DED1 2'h1
`define GCS_SEL_PLL0 2'h2
`define GCS_SEL_PLL1 2'h3

// input counts of one block
`define GCS_DED_PINS 2
`define GCS_PLL_COUNTERS 5
`define GCS_PLL_CANDIDATES 4
`define GCS_CORNER_PINS 2

// device population limits
`define GCS_EDGE_BLOCKS_MIN 5
`define GCS_EDGE_BLOCKS_MAX 6
`define GCS_MAX_BLOCKS_XCVR 30
`define GCS_MAX_BLOCKS_PLAIN 20
`define GCS_SMALL_LAST_NET 9

// reset values of the captured configuration, the runtime select register and the gate
`define GCS_RST_STATIC_SRC 2'h0
`define GCS_RST_PLL_PICK0 2'h0
`define GCS_RST_PLL_PICK1 2'h2
`define GCS_RST_CORNER_PICK 1'h0
`define GCS_RST_REF_SWITCH 1'h0
`define GCS_RST_DYN_SEL 2'h0
`define GCS_RST_GATE 1'h0

`endif

// File: design/gcs_pkg.sv
package gcs_pkg;

  // static source choice held in configuration
  typedef enum logic [1:0] {
    GCS_STATIC_DYNAMIC = 2'b00,
    GCS_STATIC_DUAL = 2'b01,
    GCS_STATIC_FABRIC = 2'b10
  } gcs_static_e;

  // block life cycle: configuration capture, then user mode
  typedef enum logic [0:0] {
    GCS_ST_CONFIG = 1'b0,
    GCS_ST_USER = 1'b1
  } gcs_state_e;

endpackage

// File: design/gcs_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pins and foreign clocks
module gcs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // foreign levels
  input wire logic [WIDTH-1:0] asyncIn,
  // levels in the ref_clk domain
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// File: design/gcs_clock_control.sv
`timescale 1ns/1ps
`include "gcs_cfg.svh"
// The network is modelled as a level sampled on ref_clk; every source
// from outside this domain is synchronised before the mux sees it.
// pin and counter levels are only passed on; nothing here divides them.
module gcs_clock_control
  import gcs_pkg::*;
#(
  parameter bit IS_TRANSCEIVER = 1'b0,
  parameter bit IS_LEFT_EDGE = 1'b0,
  parameter bit IS_SMALL_DENSITY = 1'b0,
  parameter int NETWORK_INDEX = 0,
  parameter int BLOCKS_PER_EDGE = 5,
  parameter int EDGE_COUNT = 4,
  parameter int PLL_TAP0 = 0,
  parameter int PLL_TAP1 = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // dedicated clock pins (foreign domain)
  input wire logic [`GCS_DED_PINS-1:0] dedClkPin,
  // counter outputs of the two adjacent PLLs (foreign domain)
  input wire logic [`GCS_PLL_COUNTERS-1:0] pllCounterA,
  input wire logic [`GCS_PLL_COUNTERS-1:0] pllCounterB,
  // dual-purpose and corner pins (foreign domain)
  input wire logic dualPurposePin,
  input wire logic [`GCS_CORNER_PINS-1:0] cornerPin,
  // fabric source (ref_clk domain)
  input wire logic fabricSource,
  // configuration bits, captured once after reset release
  input wire logic [1:0] cfgStaticSource,
  input wire logic cfgUseCorner,
  input wire logic cfgCornerPick,
  input wire logic [1:0] cfgPllPick0,
  input wire logic [1:0] cfgPllPick1,
  input wire logic cfgRefSwitch,
  // user-mode fabric controls (ref_clk domain)
  input wire logic [1:0] clockSourceSelect,
  input wire logic networkGateEnable,
  input wire logic manualSwitchEn,
  input wire logic manualRefSwitch,
  // network and PLL feed
  output logic globalClockNetwork,
  output logic pllReferenceInput,
  output logic pllForwardAllowed,
  // pins handed back to the fabric
  output logic [`GCS_DED_PINS-1:0] dedPinToFabric,
  output logic cornerIoData,
  // status
  output logic userMode,
  output logic [1:0] activeSelect,
  output logic gateActive
);

  // elaboration checks on the device population; a parameter set that no
  // part can have stops the build instead of giving a block that cannot exist
  if (BLOCKS_PER_EDGE < `GCS_EDGE_BLOCKS_MIN || BLOCKS_PER_EDGE > `GCS_EDGE_BLOCKS_MAX) begin
    $error("blocks per edge out of range");
  end
  if (EDGE_COUNT < 1) begin
    $error("edge count must be positive");
  end
  if (IS_TRANSCEIVER && BLOCKS_PER_EDGE * EDGE_COUNT > `GCS_MAX_BLOCKS_XCVR) begin
    $error("too many blocks for a transceiver part");
  end
  if (!IS_TRANSCEIVER && BLOCKS_PER_EDGE * EDGE_COUNT > `GCS_MAX_BLOCKS_PLAIN) begin
    $error("too many blocks for a plain part");
  end
  if (PLL_TAP0 < 0 || PLL_TAP0 >= `GCS_PLL_COUNTERS || PLL_TAP1 < 0
      || PLL_TAP1 >= `GCS_PLL_COUNTERS || PLL_TAP0 == PLL_TAP1) begin
    $error("PLL taps must be two distinct counters");
  end
  if (NETWORK_INDEX < 0) begin
    $error("network index negative");
  end

  // network exists unless a small plain part asks for a high index
  // (small plain parts build only the first ten networks)
  localparam bit NET_PRESENT = !(IS_SMALL_DENSITY && !IS_TRANSCEIVER
                                 && NETWORK_INDEX > `GCS_SMALL_LAST_NET);
  // transceiver left edge has no dedicated pin inputs
  localparam bit DED_PRESENT = !(IS_TRANSCEIVER && IS_LEFT_EDGE);

  // synchronised sources: two flops on every foreign input guard the mux
  // against metastable levels, at the cost of two cycles of latency
  logic [`GCS_DED_PINS-1:0] dedSync;
  logic [`GCS_PLL_COUNTERS-1:0] pllSyncA;
  logic [`GCS_PLL_COUNTERS-1:0] pllSyncB;
  logic [2:0] pinSync;

  gcs_sync #(.WIDTH(`GCS_DED_PINS)) u_ded_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn(dedClkPin),
    .syncOut(dedSync)
  );

  gcs_sync #(.WIDTH(`GCS_PLL_COUNTERS)) u_plla_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn(pllCounterA),
    .syncOut(pllSyncA)
  );

  gcs_sync #(.WIDTH(`GCS_PLL_COUNTERS)) u_pllb_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn(pllCounterB),
    .syncOut(pllSyncB)
  );

  gcs_sync #(.WIDTH(3)) u_pin_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn({cornerPin, dualPurposePin}),
    .syncOut(pinSync)
  );

  // captured configuration, frozen once user mode starts
  gcs_state_e state;
  gcs_static_e staticSource;
  logic useCorner;
  logic cornerPick;
  logic [1:0] pllPick0;
  logic [1:0] pllPick1;
  logic refSwitchCfg;

  // configuration is caught on the first edge after release, never at reset;
  // these fields are written in the configuration state only, so no user-mode
  // input has a path to change the static choice afterwards
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= GCS_ST_CONFIG;
      staticSource <= GCS_STATIC_DYNAMIC;
      useCorner <= 1'b0;
      cornerPick <= `GCS_RST_CORNER_PICK;
      pllPick0 <= `GCS_RST_PLL_PICK0;
      pllPick1 <= `GCS_RST_PLL_PICK1;
      refSwitchCfg <= `GCS_RST_REF_SWITCH;
    end else begin
      case (state)
        GCS_ST_CONFIG: begin
          state <= GCS_ST_USER;
          case (cfgStaticSource)
            2'h1: staticSource <= GCS_STATIC_DUAL;
            2'h2: staticSource <= GCS_STATIC_FABRIC;
            default: staticSource <= GCS_STATIC_DYNAMIC;
          endcase
          useCorner <= cfgUseCorner;
          cornerPick <= cfgCornerPick;
          pllPick0 <= cfgPllPick0;
          pllPick1 <= cfgPllPick1;
          refSwitchCfg <= cfgRefSwitch;
        end
        GCS_ST_USER: begin
          state <= GCS_ST_USER; // user logic cannot reach the fields above
        end
        default: begin
          state <= GCS_ST_CONFIG;
        end
      endcase
    end
  end

  // four PLL candidates: two global-capable counters of each adjacent PLL;
  // the other three counters of each PLL never reach the network
  logic [`GCS_PLL_CANDIDATES-1:0] pllCandidates;
  assign pllCandidates = {pllSyncB[PLL_TAP1], pllSyncB[PLL_TAP0],
                          pllSyncA[PLL_TAP1], pllSyncA[PLL_TAP0]};

  // the two PLL inputs of the block
  // the picks are frozen with the rest of the configuration
  logic pllIn0;
  logic pllIn1;
  assign pllIn0 = pllCandidates[pllPick0];
  assign pllIn1 = pllCandidates[pllPick1];

  // dedicated pins, absent on the transceiver left edge
  logic [`GCS_DED_PINS-1:0] dedIn;
  assign dedIn = DED_PRESENT ? dedSync : '0;

  // dual-purpose input: plain pin or one of the corner pair
  // only one corner pin feeds at a time; its partner stays a plain input
  logic dualIn;
  assign dualIn = useCorner ? pinSync[1 + cornerPick] : pinSync[0];

  // runtime select register; only written in user mode
  logic [1:0] dynSel;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dynSel <= `GCS_RST_DYN_SEL;
    end else if (state == GCS_ST_USER) begin
      dynSel <= clockSourceSelect;
    end
  end

  // fixed one-to-one map of select codes onto the dynamic inputs
  // a select change is not glitch free: the network may show a short stub of
  // the old source, so gate it off around a change when that matters
  logic dynamicSource;
  always_comb begin
    case (dynSel)
      `GCS_SEL_DED0: dynamicSource = dedIn[0];
      `GCS_SEL_DED1: dynamicSource = dedIn[1];
      `GCS_SEL_PLL0: dynamicSource = pllIn0;
      `GCS_SEL_PLL1: dynamicSource = pllIn1;
      default: dynamicSource = 1'b0;
    endcase
  end

  // static stage: dual-purpose and fabric inputs bypass the runtime select
  logic selectedSource;
  always_comb begin
    case (staticSource)
      GCS_STATIC_DUAL: selectedSource = dualIn;
      GCS_STATIC_FABRIC: selectedSource = fabricSource;
      GCS_STATIC_DYNAMIC: selectedSource = dynamicSource;
      default: selectedSource = 1'b0;
    endcase
  end

  // previous source level, for falling-edge detection
  logic sourcePrev;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sourcePrev <= 1'b0;
    end else begin
      sourcePrev <= selectedSource;
    end
  end

  // a select change from a high source to a low one also reads as a fall;
  // that only lets a pending gate request act at that edge
  logic sourceFall;
  assign sourceFall = sourcePrev && !selectedSource;

  // gate enable updates only on a falling source edge, so a high phase
  // is never cut short; a stopped source keeps the last gate state
  // an enable request must therefore stand until the source next falls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateActive <= `GCS_RST_GATE;
    end else if (state == GCS_ST_USER && sourceFall) begin
      gateActive <= networkGateEnable;
    end
  end

  // network output; gating acts here and on the forwarded reference, PLL counters are never touched
  // because the gate sits after the mux, a PLL behind the source keeps lock
  // and the network reopens without any relock time
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      globalClockNetwork <= 1'b0;
    end else begin
      globalClockNetwork <= NET_PRESENT && gateActive && selectedSource;
    end
  end

  // PLL feed allowed only for pin or PLL sourced blocks
  // dual-purpose and fabric sources never reach a PLL reference
  logic forwardOk;
  assign forwardOk = (staticSource == GCS_STATIC_DYNAMIC) && NET_PRESENT;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pllForwardAllowed <= 1'b0;
    end else begin
      pllForwardAllowed <= forwardOk && (state == GCS_ST_USER);
    end
  end

  // reference switch: configured value or manual switchover override
  logic refSwitch;
  assign refSwitch = manualSwitchEn ? manualRefSwitch : refSwitchCfg;

  // reference mux: dedicated pin 0, or the forwarded network when allowed
  // the forwarded network carries the gate, so gating it also starves the
  // PLL reference; keep the switch on pin 0 while gating if that hurts
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pllReferenceInput <= 1'b0;
    end else if (refSwitch) begin
      pllReferenceInput <= forwardOk && gateActive && selectedSource;
    end else begin
      pllReferenceInput <= dedIn[0];
    end
  end

  // dedicated pins, and the spare corner pin when useCorner is set, reach the fabric through ordinary registers
  // each path has its own output register here, after the two-flop synchroniser
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dedPinToFabric <= '0;
      cornerIoData <= 1'b0;
    end else begin
      dedPinToFabric <= dedIn;
      cornerIoData <= useCorner ? pinSync[2 - cornerPick] : 1'b0;
    end
  end

  // status, registered so every output leaves a flop
  // activeSelect trails the select register by one edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      userMode <= 1'b0;
      activeSelect <= `GCS_RST_DYN_SEL;
    end else begin
      userMode <= (state == GCS_ST_USER);
      activeSelect <= dynSel;
    end
  end

  // the six-input limit holds by construction of the port list: two pins,
  // two PLL candidates, one dual-purpose or corner pin and one fabric source
  // reach the muxes, and nothing else can

endmodule

// File: tb/gcs_fabric_model.sv
`timescale 1ns/1ps
// fabric logic on the far side of the block: select, gate and switchover levels
module gcs_fabric_model (
  // clock
  input wire logic ref_clk,
  // levels asked for by the test sequence
  input wire logic [1:0] wantSel,
  input wire logic wantGate,
  input wire logic wantManual,
  input wire logic wantRef,
  // levels handed to the block
  output logic [1:0] clockSourceSelect,
  output logic networkGateEnable,
  output logic manualSwitchEn,
  output logic manualRefSwitch,
  output logic fabricSource
);
  // quiet levels until the first edge
  initial begin
    clockSourceSelect = 2'h0;
    networkGateEnable = 1'b0;
    manualSwitchEn = 1'b0;
    manualRefSwitch = 1'b0;
    fabricSource = 1'b0;
  end
  // fabric registers launch just after the edge, so the block never sees a mid-edge change
  always @(posedge ref_clk) begin
    #1;
    clockSourceSelect = wantSel;
    networkGateEnable = wantGate;
    manualSwitchEn = wantManual;
    manualRefSwitch = wantRef;
    fabricSource = !fabricSource;
  end
endmodule

// File: tb/gcs_clock_control_checker.sv
`timescale 1ns/1ps
module gcs_clock_control_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched inputs
  input wire logic [1:0] dedClkPin,
  input wire logic [1:0] cfgStaticSource,
  input wire logic cfgRefSwitch,
  input wire logic [1:0] clockSourceSelect,
  input wire logic networkGateEnable,
  input wire logic manualSwitchEn,
  // watched outputs
  input wire logic globalClockNetwork,
  input wire logic pllReferenceInput,
  input wire logic pllForwardAllowed,
  input wire logic [1:0] dedPinToFabric,
  input wire logic userMode,
  input wire logic [1:0] activeSelect,
  input wire logic gateActive
);
  logic capt;
  logic [1:0] st;
  logic rs;
  // shadow of the latched configuration; later pin changes must not count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      capt <= 1'b0;
      st <= 2'h0;
      rs <= 1'b0;
    end else if (!capt) begin
      capt <= 1'b1;
      st <= cfgStaticSource;
      rs <= cfgRefSwitch;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_cfg_off;
    !userMode |-> !gateActive && !globalClockNetwork && !pllForwardAllowed;
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("network live outside user mode");
  property p_sel;
    userMode |=> activeSelect == $past(clockSourceSelect, 2);
  endproperty
  a_sel: assert property (p_sel) else $error("select not followed");
  property p_gate;
    $changed(gateActive) |-> gateActive == $past(networkGateEnable);
  endproperty
  a_gate: assert property (p_gate) else $error("gate took a wrong value");
  property p_off;
    !gateActive |=> !globalClockNetwork;
  endproperty
  a_off: assert property (p_off) else $error("gated network moved");
  property p_fwd;
    pllForwardAllowed |-> capt && st != 2'h1 && st != 2'h2;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward from pin or fabric source");
  property p_route;
    $past(userMode) && $past(gateActive) && st != 2'h1 && st != 2'h2 && !activeSelect[1]
      |-> globalClockNetwork == (activeSelect[0] ? $past(dedClkPin[1], 3)
      : $past(dedClkPin[0], 3));
  endproperty
  a_route: assert property (p_route) else $error("wrong dedicated pin on network");
  property p_ref;
    $past(userMode) && !manualSwitchEn && !$past(manualSwitchEn) && !rs
      |-> pllReferenceInput == $past(dedClkPin[0], 3);
  endproperty
  a_ref: assert property (p_ref) else $error("reference not from pin 0");
  property p_fab;
    $past(userMode) |-> dedPinToFabric == $past(dedClkPin, 3);
  endproperty
  a_fab: assert property (p_fab) else $error("pin to fabric wrong");
endmodule

bind gcs_clock_control gcs_clock_control_checker chk (
  .ref_clk(ref_clk), .resetn(resetn), .dedClkPin(dedClkPin),
  .cfgStaticSource(cfgStaticSource), .cfgRefSwitch(cfgRefSwitch),
  .clockSourceSelect(clockSourceSelect), .networkGateEnable(networkGateEnable),
  .manualSwitchEn(manualSwitchEn), .globalClockNetwork(globalClockNetwork),
  .pllReferenceInput(pllReferenceInput), .pllForwardAllowed(pllForwardAllowed),
  .dedPinToFabric(dedPinToFabric), .userMode(userMode), .activeSelect(activeSelect),
  .gateActive(gateActive)
);

// File: tb/test_gcs_clock_control.sv
`timescale 1ns/1ps
module test_gcs_clock_control;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b1;
  logic [7:0] cnt = 8'h00;
  logic [1:0] cfgStaticSource = 2'h0;
  logic cfgUseCorner = 1'b0;
  logic cfgCornerPick = 1'b0;
  logic cfgRefSwitch = 1'b0;
  logic [1:0] wantSel = 2'h0;
  logic wantGate = 1'b0;
  logic wantManual = 1'b0;
  logic wantRef = 1'b0;
  logic [1:0] dedClkPin, cornerPin, clockSourceSelect, activeSelect, dedPinToFabric;
  logic [4:0] pllCounterA, pllCounterB;
  logic dualPurposePin, fabricSource, networkGateEnable, manualSwitchEn, manualRefSwitch;
  logic globalClockNetwork, pllReferenceInput, pllForwardAllowed, cornerIoData;
  logic userMode, gateActive;
  int miscompares = 0;
  int testsRun = 0;
  int cycles = 0;
  int n;
  // foreign sources are slow clocks cut from one counter; freezing it holds every pin
  assign dedClkPin = {cnt[2], cnt[1]};
  assign pllCounterA = cnt[6:2];
  assign pllCounterB = ~cnt[6:2];
  assign cornerPin = {cnt[3], ~cnt[3]};
  assign dualPurposePin = cnt[2];
  always #25 ref_clk = !ref_clk;
  // pins move just after the edge; the cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    #1;
    if (run) cnt = cnt + 8'h01;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  gcs_fabric_model fab (.ref_clk(ref_clk), .wantSel(wantSel), .wantGate(wantGate),
    .wantManual(wantManual), .wantRef(wantRef), .clockSourceSelect(clockSourceSelect),
    .networkGateEnable(networkGateEnable), .manualSwitchEn(manualSwitchEn),
    .manualRefSwitch(manualRefSwitch), .fabricSource(fabricSource));
  gcs_clock_control #(.PLL_TAP0(0), .PLL_TAP1(1)) uut (.ref_clk(ref_clk), .resetn(resetn),
    .dedClkPin(dedClkPin), .pllCounterA(pllCounterA), .pllCounterB(pllCounterB),
    .dualPurposePin(dualPurposePin), .cornerPin(cornerPin), .fabricSource(fabricSource),
    .cfgStaticSource(cfgStaticSource), .cfgUseCorner(cfgUseCorner),
    .cfgCornerPick(cfgCornerPick), .cfgPllPick0(2'h0), .cfgPllPick1(2'h3),
    .cfgRefSwitch(cfgRefSwitch), .clockSourceSelect(clockSourceSelect),
    .networkGateEnable(networkGateEnable), .manualSwitchEn(manualSwitchEn),
    .manualRefSwitch(manualRefSwitch), .globalClockNetwork(globalClockNetwork),
    .pllReferenceInput(pllReferenceInput), .pllForwardAllowed(pllForwardAllowed),
    .dedPinToFabric(dedPinToFabric), .cornerIoData(cornerIoData), .userMode(userMode),
    .activeSelect(activeSelect), .gateActive(gateActive));
  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // sample two units after the edge, once the fabric drivers have settled
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  task automatic toggles(input int k, output int t);
    logic last;
    t = 0;
    last = globalClockNetwork;
    repeat (k) begin
      tick(1);
      if (globalClockNetwork !== last) t++;
      last = globalClockNetwork;
    end
  endtask
  task automatic boot(input logic [1:0] st, input logic uc, input logic cp);
    resetn = 1'b0;
    cfgStaticSource = st;
    cfgUseCorner = uc;
    cfgCornerPick = cp;
    tick(4);
    chk({userMode, globalClockNetwork}, 2'h0, "outputs in reset");
    resetn = 1'b1;
    tick(2);
    chk({1'b0, userMode}, 2'h1, "user mode");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    boot(2'h0, 1'b0, 1'b0);
    wantGate = 1'b1;
    tick(12);
    chk({pllForwardAllowed, gateActive}, 2'h3, "gate on, forward");
    // every select code must land on a moving source
    for (int i = 0; i < 4; i++) begin
      wantSel = i[1:0];
      tick(3);
      chk(activeSelect, i[1:0], "select");
      toggles(40, n);
      chk({1'b0, n > 0}, 2'h1, "network idle");
    end
    wantGate = 1'b0;
    tick(20);
    toggles(16, n);
    chk({gateActive, n != 0}, 2'h0, "gated network moved");
    // a stopped source must freeze the gate even when enable returns
    run = 1'b0;
    tick(4);
    wantGate = 1'b1;
    tick(10);
    chk({1'b0, gateActive}, 2'h0, "gate moved without falling edge");
    chk(dedPinToFabric, {cnt[2], cnt[1]}, "pins to fabric");
    wantManual = 1'b1;
    tick(4);
    chk({1'b0, pllReferenceInput}, {1'b0, cnt[1]}, "manual reference pin");
    run = 1'b1;
    tick(22);
    chk({1'b0, gateActive}, 2'h1, "gate after falling edge");
    cfgStaticSource = 2'h2;
    run = 1'b0;
    wantRef = 1'b1;
    tick(6);
    chk({pllForwardAllowed, pllReferenceInput}, {1'b1, ~cnt[3]}, "ref from network");
    run = 1'b1;
    // dual source taken from corner pin 1; pin 0 stays ordinary I/O
    boot(2'h1, 1'b1, 1'b1);
    tick(12);
    toggles(30, n);
    chk({pllForwardAllowed, n > 0}, 2'h1, "dual source");
    run = 1'b0;
    tick(4);
    chk({1'b0, cornerIoData}, {1'b0, ~cnt[3]}, "corner spare pin");
    run = 1'b1;
    boot(2'h2, 1'b0, 1'b0);
    tick(12);
    toggles(30, n);
    chk({pllForwardAllowed, n > 0}, 2'h1, "fabric source");
    stop_test();
  end
endmodule
